/* File: shared/fps_pkg.sv */
// Overview of operation
// - A program request is four write cycles; the last one carries target address and data.
// - Whole-chip erase in sixteen-bit mode uses address 555h in its erase cycles.
// - Sector erase places an address inside the sector on the final cycle.
// - Sector erase completion is polled at an address inside the erased sector.
// - Completion is polled at the command address even in a protected sector, whose status may be invalid.
// - After the timeout flag reads 1, the data-poll bit is read once more.
// - Running state is judged by comparing the toggle bit over two consecutive reads.
// - After the timeout flag reads 1, the toggle bit is checked once more.
package fps_pkg;

    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;

    localparam int CLK_PERIOD_PS = 4000;
    localparam int T_WP_NS       = 50;
    localparam int T_WPH_NS      = 30;
    localparam int T_ACC_NS      = 100;
    localparam int T_OEH_NS      = 10;
    localparam int SYNC_STAGES   = 2;

    localparam int WP_CYC  = (T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WPH_CYC = (T_WPH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACC_CYC = (T_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS
                             + SYNC_STAGES;
    localparam int OEH_CYC = (T_OEH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 19'h00555;
    localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 19'h002AA;

    localparam logic [DATA_W-1:0] CODE_UNLOCK1   = 16'h00AA;
    localparam logic [DATA_W-1:0] CODE_UNLOCK2   = 16'h0055;
    localparam logic [DATA_W-1:0] CODE_PROGRAM   = 16'h00A0;
    localparam logic [DATA_W-1:0] CODE_ERASE     = 16'h0080;
    localparam logic [DATA_W-1:0] CODE_CHIP_ERS  = 16'h0010;
    localparam logic [DATA_W-1:0] CODE_SECT_ERS  = 16'h0030;
    localparam logic [DATA_W-1:0] CODE_RESET     = 16'h00F0;

    localparam int DATA_POLL_POS = 7;
    localparam int TOGGLE_POS    = 6;
    localparam int TIMEOUT_POS   = 5;

    localparam logic [2:0] LAST_STEP_PROGRAM = 3'h3;
    localparam logic [2:0] LAST_STEP_ERASE   = 3'h5;
    localparam logic [2:0] LAST_STEP_RESET   = 3'h0;

    typedef enum logic [2:0] {
        FPS_OP_READ,
        FPS_OP_PROGRAM,
        FPS_OP_CHIP_ERASE,
        FPS_OP_SECTOR_ERASE,
        FPS_OP_RESET
    } fps_op_t;

endpackage : fps_pkg

/* File: logic/fps_host.sv */
`timescale 1ns/10ps
module fps_host (
    input  wire logic                        mclk,
    input  wire logic                        nrst,
    input  wire logic                        mclk_en,
    input  wire logic                        cmd_valid,
    output logic                             cmd_ready,
    input  wire fps_pkg::fps_op_t            cmd_op,
    input  wire logic [fps_pkg::ADDR_W-1:0]  cmd_addr,
    input  wire logic [fps_pkg::DATA_W-1:0]  cmd_data,
    input  wire logic                        cmd_toggle_mode,
    output logic                             rsp_done,
    output logic                             rsp_fail,
    output logic [fps_pkg::DATA_W-1:0]       rsp_rdata,
    output logic                             flash_ce_n,
    output logic                             flash_oe_n,
    output logic                             flash_we_n,
    output logic                             flash_reset_n,
    output logic [fps_pkg::ADDR_W-1:0]       flash_addr,
    output logic [fps_pkg::DATA_W-1:0]       flash_dq_out,
    output logic                             flash_dq_oe,
    input  wire logic [fps_pkg::DATA_W-1:0]  flash_dq_in
);

    typedef enum logic [2:0] {
        ST_IDLE, ST_WR_LOW, ST_WR_HIGH, ST_RD_WAIT, ST_RD_GAP
    } fps_state_t;

    typedef struct packed {
        fps_state_t                  st;
        fps_pkg::fps_op_t            op;
        logic [2:0]                  step;
        logic [7:0]                  cnt;
        logic [fps_pkg::ADDR_W-1:0]  addr;
        logic [fps_pkg::DATA_W-1:0]  dout;
        logic                        doe;
        logic                        ce_n;
        logic                        oe_n;
        logic                        we_n;
        logic [fps_pkg::ADDR_W-1:0]  pa;
        logic [fps_pkg::DATA_W-1:0]  pd;
        logic                        tmode;
        logic                        recheck;
        logic                        have_prev;
        logic                        prev_tog;
        logic                        failed;
        logic [fps_pkg::DATA_W-1:0]  sync1;
        logic [fps_pkg::DATA_W-1:0]  sync2;
        logic [fps_pkg::DATA_W-1:0]  rdata;
        logic                        done;
    } fps_regs_t;

    fps_regs_t s_reg;
    fps_regs_t s_next;

    function automatic logic [2:0] last_step(input fps_pkg::fps_op_t op);
        unique case (op)
            fps_pkg::FPS_OP_PROGRAM:      last_step = fps_pkg::LAST_STEP_PROGRAM;
            fps_pkg::FPS_OP_CHIP_ERASE,
            fps_pkg::FPS_OP_SECTOR_ERASE: last_step = fps_pkg::LAST_STEP_ERASE;
            default:                      last_step = fps_pkg::LAST_STEP_RESET;
        endcase
    endfunction : last_step

    function automatic logic [fps_pkg::ADDR_W-1:0] step_addr(
        input fps_pkg::fps_op_t op, input logic [2:0] step,
        input logic [fps_pkg::ADDR_W-1:0] pa);
        step_addr = fps_pkg::ADDR_UNLOCK1;
        if (step == 3'h1 || step == 3'h4) begin
            step_addr = fps_pkg::ADDR_UNLOCK2;
        end
        if (op == fps_pkg::FPS_OP_PROGRAM && step == 3'h3) begin
            step_addr = pa;
        end
        if (op == fps_pkg::FPS_OP_SECTOR_ERASE && step == 3'h5) begin
            step_addr = pa;
        end
    endfunction : step_addr

    function automatic logic [fps_pkg::DATA_W-1:0] step_data(
        input fps_pkg::fps_op_t op, input logic [2:0] step,
        input logic [fps_pkg::DATA_W-1:0] pd);
        unique case (step)
            3'h0:    step_data = fps_pkg::CODE_UNLOCK1;
            3'h1:    step_data = fps_pkg::CODE_UNLOCK2;
            3'h2:    step_data = (op == fps_pkg::FPS_OP_PROGRAM) ? fps_pkg::CODE_PROGRAM
                                                               : fps_pkg::CODE_ERASE;
            3'h3:    step_data = (op == fps_pkg::FPS_OP_PROGRAM) ? pd
                                                               : fps_pkg::CODE_UNLOCK1;
            3'h4:    step_data = fps_pkg::CODE_UNLOCK2;
            default: step_data = (op == fps_pkg::FPS_OP_CHIP_ERASE) ? fps_pkg::CODE_CHIP_ERS
                                                                  : fps_pkg::CODE_SECT_ERS;
        endcase
        if (op == fps_pkg::FPS_OP_RESET) begin
            step_data = fps_pkg::CODE_RESET;
        end
    endfunction : step_data

    logic cur_poll;
    logic cur_tog;
    logic cur_tout;
    logic want_poll;

    always_comb begin
        s_next = s_reg;
        s_next.sync1 = flash_dq_in;
        s_next.sync2 = s_reg.sync1;
        s_next.done = 1'b0;
        cur_poll = s_reg.rdata[fps_pkg::DATA_POLL_POS];
        cur_tog = s_reg.rdata[fps_pkg::TOGGLE_POS];
        cur_tout = s_reg.rdata[fps_pkg::TIMEOUT_POS];
        // An erased cell reads all ones, so erase completes when the poll bit is one.
        want_poll = (s_reg.op == fps_pkg::FPS_OP_PROGRAM) ?
                    s_reg.pd[fps_pkg::DATA_POLL_POS] : 1'b1;
        if (s_reg.cnt != 8'h00) begin
            s_next.cnt = s_reg.cnt - 8'h01;
        end
        unique case (s_reg.st)
            ST_IDLE: begin
                if (cmd_valid) begin
                    s_next.op = cmd_op;
                    s_next.pa = cmd_addr;
                    s_next.pd = cmd_data;
                    s_next.tmode = cmd_toggle_mode;
                    s_next.step = 3'h0;
                    s_next.recheck = 1'b0;
                    s_next.have_prev = 1'b0;
                    s_next.failed = 1'b0;
                    s_next.ce_n = 1'b0;
                    if (cmd_op == fps_pkg::FPS_OP_READ) begin
                        s_next.addr = cmd_addr;
                        s_next.oe_n = 1'b0;
                        s_next.cnt = 8'(fps_pkg::ACC_CYC);
                        s_next.st = ST_RD_WAIT;
                    end else begin
                        s_next.addr = step_addr(cmd_op, 3'h0, cmd_addr);
                        s_next.dout = step_data(cmd_op, 3'h0, cmd_data);
                        s_next.doe = 1'b1;
                        s_next.we_n = 1'b0;
                        s_next.cnt = 8'(fps_pkg::WP_CYC);
                        s_next.st = ST_WR_LOW;
                    end
                end
            end
            ST_WR_LOW: begin
                if (s_reg.cnt == 8'h00) begin
                    s_next.we_n = 1'b1;
                    s_next.cnt = 8'(fps_pkg::WPH_CYC);
                    s_next.st = ST_WR_HIGH;
                end
            end
            ST_WR_HIGH: begin
                if (s_reg.cnt == 8'h00) begin
                    if (s_reg.step != last_step(s_reg.op)) begin
                        s_next.step = s_reg.step + 3'h1;
                        s_next.addr = step_addr(s_reg.op, s_reg.step + 3'h1, s_reg.pa);
                        s_next.dout = step_data(s_reg.op, s_reg.step + 3'h1, s_reg.pd);
                        s_next.we_n = 1'b0;
                        s_next.cnt = 8'(fps_pkg::WP_CYC);
                        s_next.st = ST_WR_LOW;
                    end else if (s_reg.op == fps_pkg::FPS_OP_RESET) begin
                        s_next.doe = 1'b0;
                        s_next.ce_n = 1'b1;
                        s_next.done = 1'b1;
                        s_next.st = ST_IDLE;
                    end else begin
                        // Polling stays on the command address, inside the target sector.
                        s_next.addr = s_reg.pa;
                        s_next.doe = 1'b0;
                        s_next.oe_n = 1'b0;
                        s_next.cnt = 8'(fps_pkg::ACC_CYC);
                        s_next.st = ST_RD_WAIT;
                    end
                end
            end
            ST_RD_WAIT: begin
                if (s_reg.cnt == 8'h00) begin
                    s_next.rdata = s_reg.sync2;
                    s_next.oe_n = 1'b1;
                    s_next.cnt = 8'(fps_pkg::OEH_CYC);
                    s_next.st = ST_RD_GAP;
                end
            end
            ST_RD_GAP: begin
                if (s_reg.cnt == 8'h00) begin
                    s_next.st = ST_RD_WAIT;
                    s_next.oe_n = 1'b0;
                    s_next.cnt = 8'(fps_pkg::ACC_CYC);
                    if (s_reg.op == fps_pkg::FPS_OP_READ) begin
                        s_next.oe_n = 1'b1;
                        s_next.ce_n = 1'b1;
                        s_next.done = 1'b1;
                        s_next.st = ST_IDLE;
                    end else if (!s_reg.tmode) begin
                        if (cur_poll == want_poll) begin
                            s_next.oe_n = 1'b1;
                            s_next.ce_n = 1'b1;
                            s_next.done = 1'b1;
                            s_next.st = ST_IDLE;
                        end else if (s_reg.recheck) begin
                            s_next.failed = 1'b1;
                        end else if (cur_tout) begin
                            s_next.recheck = 1'b1;
                        end
                    end else begin
                        s_next.prev_tog = cur_tog;
                        s_next.have_prev = 1'b1;
                        if (s_reg.have_prev && s_reg.prev_tog == cur_tog) begin
                            s_next.oe_n = 1'b1;
                            s_next.ce_n = 1'b1;
                            s_next.done = 1'b1;
                            s_next.st = ST_IDLE;
                        end else if (s_reg.have_prev && s_reg.recheck) begin
                            s_next.failed = 1'b1;
                        end else if (s_reg.have_prev && cur_tout) begin
                            s_next.recheck = 1'b1;
                        end
                    end
                    if (s_next.failed && !s_reg.failed) begin
                        s_next.op = fps_pkg::FPS_OP_RESET;
                        s_next.step = 3'h0;
                        s_next.oe_n = 1'b1;
                        s_next.addr = step_addr(fps_pkg::FPS_OP_RESET, 3'h0, s_reg.pa);
                        s_next.dout = fps_pkg::CODE_RESET;
                        s_next.doe = 1'b1;
                        s_next.we_n = 1'b0;
                        s_next.cnt = 8'(fps_pkg::WP_CYC);
                        s_next.st = ST_WR_LOW;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s_reg <= '{st: ST_IDLE, op: fps_pkg::FPS_OP_READ, ce_n: 1'b1, oe_n: 1'b1,
                       we_n: 1'b1, default: '0};
        end else if (mclk_en) begin
            s_reg <= s_next;
        end
    end

    assign cmd_ready     = (s_reg.st == ST_IDLE);
    assign rsp_done      = s_reg.done;
    assign rsp_fail      = s_reg.failed;
    assign rsp_rdata     = s_reg.rdata;
    assign flash_ce_n    = s_reg.ce_n;
    assign flash_oe_n    = s_reg.oe_n;
    assign flash_we_n    = s_reg.we_n;
    assign flash_reset_n = 1'b1;
    assign flash_addr    = s_reg.addr;
    assign flash_dq_out  = s_reg.dout;
    assign flash_dq_oe   = s_reg.doe;

    logic [2:0] we_falls;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            we_falls <= 3'h0;
        end else if (mclk_en) begin
            // The first write strobe already falls on the accepting edge.
            we_falls <= (cmd_valid && cmd_ready) ? {2'h0, !s_next.we_n}
                                                 : we_falls + {2'h0, s_reg.we_n && !s_next.we_n};
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    AST_PROG_FOUR_WRITES: assert property (
        s_reg.st == ST_WR_HIGH && s_next.st == ST_RD_WAIT && mclk_en
        && s_reg.op == fps_pkg::FPS_OP_PROGRAM |-> we_falls == 3'h4
    ) else $error("program sequence did not take four write cycles");
    AST_PROG_LAST_PAIR: assert property (
        $fell(flash_we_n) && s_reg.op == fps_pkg::FPS_OP_PROGRAM && s_reg.step == 3'h3
        |-> flash_addr == s_reg.pa && flash_dq_out == s_reg.pd && flash_dq_oe
    ) else $error("last program cycle lacks target address or data");
    AST_CHIP_ERASE_ADDR: assert property (
        $fell(flash_we_n) && s_reg.op == fps_pkg::FPS_OP_CHIP_ERASE && s_reg.step == 3'h5
        |-> flash_addr == fps_pkg::ADDR_UNLOCK1
    ) else $error("chip erase final cycle not at 555h");
    AST_SECTOR_ADDR: assert property (
        $fell(flash_we_n) && s_reg.op == fps_pkg::FPS_OP_SECTOR_ERASE && s_reg.step == 3'h5
        |-> flash_addr == s_reg.pa && flash_dq_out == fps_pkg::CODE_SECT_ERS
    ) else $error("sector erase final cycle outside sector");
    AST_POLL_ADDR: assert property (
        !flash_oe_n && s_reg.op != fps_pkg::FPS_OP_READ |-> flash_addr == s_reg.pa
    ) else $error("status read away from command address");
    AST_DATA_RECHECK: assert property (
        $rose(rsp_fail) && !s_reg.tmode |-> $past(s_reg.recheck)
    ) else $error("data-poll failure without a recheck read");
    AST_TOGGLE_TWO_READS: assert property (
        $rose(rsp_done) && s_reg.tmode && !rsp_fail && $past(s_reg.op) != fps_pkg::FPS_OP_READ
        && $past(s_reg.op) != fps_pkg::FPS_OP_RESET
        |-> $past(s_reg.have_prev)
    ) else $error("toggle completion judged from one read");
    AST_TOGGLE_RECHECK: assert property (
        $rose(rsp_fail) && s_reg.tmode |-> $past(s_reg.recheck)
    ) else $error("toggle failure without a recheck");
    AST_FAIL_RESETS: assert property (
        $rose(rsp_fail) |-> ##[0:40] ($fell(flash_we_n) && flash_dq_out == fps_pkg::CODE_RESET)
    ) else $error("failure not followed by a reset command");

    COV_PROGRAM_OK: cover property (
        $rose(rsp_done) && !rsp_fail && $past(s_reg.op) == fps_pkg::FPS_OP_PROGRAM);
    COV_SECTOR_ERASE: cover property (
        $rose(rsp_done) && $past(s_reg.op) == fps_pkg::FPS_OP_SECTOR_ERASE);
    COV_TOGGLE_DONE: cover property ($rose(rsp_done) && s_reg.tmode && !rsp_fail);
    COV_FAIL: cover property ($rose(rsp_done) && rsp_fail);

endmodule : fps_host

/* File: dv/fps_flash_model.sv */
`timescale 1ns/10ps
module fps_flash_model #(
    parameter logic [3:0] PROT_SECT  = 4'h7,
    parameter int         BUSY_READS = 3
) (
    input  wire logic                       ce_n,
    input  wire logic                       oe_n,
    input  wire logic                       we_n,
    input  wire logic [fps_pkg::ADDR_W-1:0] addr,
    input  wire logic [fps_pkg::DATA_W-1:0] dq_in,
    output logic      [fps_pkg::DATA_W-1:0] dq_out,
    input  wire logic                       unprot,
    input  wire logic                       stuck,
    output logic      [7:0]                 n_writes,
    output logic      [7:0]                 n_resets,
    output logic      [fps_pkg::ADDR_W-1:0] cmd_addr_seen,
    output logic      [fps_pkg::ADDR_W-1:0] poll_addr
);
    logic [15:0] mem [logic [18:0]];
    logic [2:0]  step    = 3'h0;
    logic        busy    = 1'b0;
    logic        tog     = 1'b0;
    logic        erase   = 1'b0;
    logic        chip    = 1'b0;
    int          left    = 0;
    logic [18:0] op_addr = 19'h0;
    logic [15:0] op_data = 16'h0;
    logic [15:0] val;
    wire         u1 = addr == fps_pkg::ADDR_UNLOCK1 && dq_in == fps_pkg::CODE_UNLOCK1;
    wire         u2 = addr == fps_pkg::ADDR_UNLOCK2 && dq_in == fps_pkg::CODE_UNLOCK2;

    initial begin
        dq_out = 16'h5A5A;
        n_writes = 8'h00;
        n_resets = 8'h00;
        cmd_addr_seen = 19'h0;
        poll_addr = 19'h0;
    end

    function automatic logic [15:0] rd(input logic [18:0] a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction : rd

    function automatic logic locked(input logic [18:0] a);
        return (a[18:15] == PROT_SECT) && !unprot;
    endfunction : locked

    always @(posedge we_n) begin
        if (!ce_n) begin
            n_writes = n_writes + 8'h01;
            // A data word equal to the reset code is still data in the program cycle.
            if (dq_in == fps_pkg::CODE_RESET && step != 3'h7) begin
                n_resets = n_resets + 8'h01;
                step = 3'h0;
                busy = 1'b0;
            end else begin
                case (step)
                    3'h0: step = u1 ? 3'h1 : 3'h0;
                    3'h1: step = u2 ? 3'h2 : 3'h0;
                    3'h2: step = (dq_in == fps_pkg::CODE_PROGRAM) ? 3'h7
                               : (dq_in == fps_pkg::CODE_ERASE) ? 3'h3 : 3'h0;
                    3'h3: step = u1 ? 3'h4 : 3'h0;
                    3'h4: step = u2 ? 3'h5 : 3'h0;
                    default: begin
                        cmd_addr_seen = addr;
                        erase = step == 3'h5;
                        chip = erase && dq_in == fps_pkg::CODE_CHIP_ERS;
                        op_addr = addr;
                        op_data = dq_in;
                        busy = !locked(addr);
                        left = BUSY_READS;
                        step = 3'h0;
                    end
                endcase
            end
        end
    end

    // Chip enable and output enable may fall in one time step, in either order.
    always @(negedge oe_n or negedge ce_n) begin
        if (!ce_n && !oe_n) begin
            poll_addr = addr;
            if (busy) begin
                left = left - 1;
            end
            if (busy && !stuck && left <= 0) begin
                if (erase) begin
                    foreach (mem[a]) begin
                        if (!locked(a) && (chip || a[18:15] == op_addr[18:15])) begin
                            mem[a] = 16'hFFFF;
                        end
                    end
                end else begin
                    mem[op_addr] = rd(op_addr) & op_data;
                end
                busy = 1'b0;
            end
            if (busy) begin
                tog = !tog;
                val = 16'h0000;
                val[7] = erase ? 1'b0 : !op_data[7];
                val[6] = tog;
                val[5] = stuck && left <= 0;
            end else begin
                val = rd(addr);
            end
            dq_out <= #40 val;
        end
    end

    // Released bus shows the inverse of the last word so stale data never passes.
    always @(posedge oe_n) dq_out <= #20 ~dq_out;
endmodule : fps_flash_model

/* File: dv/fps_host_tb.sv */
`timescale 1ns/10ps
module fps_host_tb;
    logic                 mclk = 1'b0;
    logic                 nrst = 1'b0;
    logic                 mclk_en = 1'b1;
    logic                 cmd_valid = 1'b0;
    logic                 cmd_toggle_mode = 1'b0;
    logic                 unprot = 1'b0;
    logic                 stuck = 1'b0;
    fps_pkg::fps_op_t     cmd_op = fps_pkg::FPS_OP_READ;
    logic [18:0]          cmd_addr = 19'h0;
    logic [15:0]          cmd_data = 16'h0;
    logic                 cmd_ready, rsp_done, rsp_fail, ce_n, oe_n, we_n, dq_oe, pin_rst_n;
    logic [15:0]          rsp_rdata, host_dq, dev_dq, dq_in;
    logic [18:0]          fl_addr, cmd_seen, poll_addr;
    logic [7:0]           n_writes, n_resets;
    int                   num_errors = 0;
    int                   cmp_count = 0;

    assign dq_in = dq_oe ? host_dq : dev_dq;

    fps_host dut_u (.mclk(mclk), .nrst(nrst), .mclk_en(mclk_en), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_toggle_mode(cmd_toggle_mode), .rsp_done(rsp_done), .rsp_fail(rsp_fail),
        .rsp_rdata(rsp_rdata), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .flash_reset_n(pin_rst_n), .flash_addr(fl_addr), .flash_dq_out(host_dq),
        .flash_dq_oe(dq_oe), .flash_dq_in(dq_in));

    fps_flash_model fl_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(fl_addr),
        .dq_in(host_dq), .dq_out(dev_dq), .unprot(unprot), .stuck(stuck),
        .n_writes(n_writes), .n_resets(n_resets), .cmd_addr_seen(cmd_seen),
        .poll_addr(poll_addr));

    initial begin
        forever #2 mclk = ~mclk;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task wrap_up;
        if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    task run_op(input fps_pkg::fps_op_t op, input logic [18:0] a, input logic [15:0] d,
                input logic tm, input logic frz);
        int n;
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        cmd_toggle_mode <= tm;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        if (frz) begin
            mclk_en <= 1'b0;
            repeat (6) @(posedge mclk);
            mclk_en <= 1'b1;
        end
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (rsp_done !== 1'b1 && n < 3000);
        check(32'(rsp_done), 32'h1);
    endtask : run_op

    task rd_chk(input logic [18:0] a, input logic [15:0] exp);
        run_op(fps_pkg::FPS_OP_READ, a, 16'h0, 1'b0, 1'b0);
        check(32'(rsp_rdata), 32'(exp));
    endtask : rd_chk

    task t_program(input logic [18:0] a, input logic [15:0] d, input logic tm, input logic frz);
        logic [7:0] w0;
        w0 = n_writes;
        run_op(fps_pkg::FPS_OP_PROGRAM, a, d, tm, frz);
        check(32'(rsp_fail), 32'h0);
        check(32'(rsp_rdata), 32'(d));
        check(32'(n_writes - w0), 32'h4);
        check(32'(poll_addr), 32'(a));
        rd_chk(a, d);
    endtask : t_program

    task t_erase(input logic chip);
        logic [7:0] w0;
        t_program(19'h09000, 16'h0F0F, 1'b0, 1'b0);
        w0 = n_writes;
        run_op(chip ? fps_pkg::FPS_OP_CHIP_ERASE : fps_pkg::FPS_OP_SECTOR_ERASE,
               19'h09010, 16'h0, !chip, 1'b0);
        check(32'(rsp_fail), 32'h0);
        check(32'(n_writes - w0), 32'h6);
        check(32'(cmd_seen), chip ? 32'h555 : 32'h9010);
        check(32'(poll_addr), 32'h9010);
        rd_chk(19'h09000, 16'hFFFF);
        rd_chk(19'h01234, chip ? 16'hFFFF : 16'h1234);
    endtask : t_erase

    task t_fail(input logic tm);
        logic [7:0] r0;
        r0 = n_resets;
        stuck <= 1'b1;
        run_op(fps_pkg::FPS_OP_PROGRAM, 19'h02000, 16'h0055, tm, 1'b0);
        check(32'(rsp_fail), 32'h1);
        check(32'(n_resets - r0), 32'h1);
        check(32'(pin_rst_n), 32'h1);
        stuck <= 1'b0;
        rd_chk(19'h02000, 16'hFFFF);
    endtask : t_fail

    task t_reset;
        logic [7:0] r0;
        r0 = n_resets;
        run_op(fps_pkg::FPS_OP_RESET, 19'h00000, 16'h0000, 1'b1, 1'b0);
        check(32'(rsp_fail), 32'h0);
        check(32'(n_resets - r0), 32'h1);
    endtask : t_reset

    task t_protect;
        t_program(19'h38000, 16'hFFFF, 1'b0, 1'b0);
        run_op(fps_pkg::FPS_OP_PROGRAM, 19'h38001, 16'h00F0, 1'b0, 1'b0);
        rd_chk(19'h38001, 16'hFFFF);
        unprot <= 1'b1;
        run_op(fps_pkg::FPS_OP_PROGRAM, 19'h38002, 16'h00F0, 1'b1, 1'b0);
        rd_chk(19'h38002, 16'h00F0);
        unprot <= 1'b0;
        run_op(fps_pkg::FPS_OP_PROGRAM, 19'h38003, 16'h00F0, 1'b0, 1'b0);
        rd_chk(19'h38003, 16'hFFFF);
    endtask : t_protect

    initial begin
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        t_program(19'h01234, 16'h1234, 1'b0, 1'b0);
        t_program(19'h01235, 16'h12B4, 1'b1, 1'b1);
        t_erase(1'b0);
        t_erase(1'b1);
        t_fail(1'b0);
        t_fail(1'b1);
        t_reset;
        t_protect;
        wrap_up;
    end

    // The whole sequence needs well under ten thousand cycles.
    initial begin
        repeat (40000) @(posedge mclk);
        num_errors++;
        wrap_up;
    end
endmodule : fps_host_tb
